//--- test/test_cpu_subset_swap_skip_table_xor.sv
// Self-checking bench for the csx_exec instruction execution unit.
// Assumes the bench plays sequencer, data memory and program memory itself.
`timescale 1ns/1ns
`include "csx_regs.svh"

module test_cpu_subset_swap_skip_table_xor;
  logic                     core_clk;
  logic                     rst_n;
  logic                     instr_valid;
  csx_pkg::csx_op_e         instr_op;
  logic [7:0]               instr_addr;
  logic [7:0]               instr_imm;
  logic [2:0]               instr_bit;
  logic [7:0]               mem_rd_data;
  logic [7:0]               table_pointer_low;
  logic [2:0]               table_pointer_high;
  logic [2:0]               current_page;
  logic [15:0]              prog_rd_data;
  logic                     busy;
  logic                     skip_next;
  logic [7:0]               work_register;
  logic                     signed_range_flag;
  logic                     result_null_flag;
  logic                     half_byte_borrow_flag;
  logic                     borrow_inverse_flag;
  logic [7:0]               table_high_latch;
  logic                     mem_wr_en;
  logic [7:0]               mem_wr_addr;
  logic [7:0]               mem_wr_data;
  logic                     prog_rd_en;
  logic [10:0]              prog_rd_addr;
  logic [3:0]               flags;
  int                       fail_count;
  int                       cmp_count;
  int                       cycles;

  assign flags = {signed_range_flag, result_null_flag, half_byte_borrow_flag, borrow_inverse_flag};

  csx_exec i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_addr(instr_addr), .instr_imm(instr_imm), .instr_bit(instr_bit), .mem_rd_data(mem_rd_data),
    .table_pointer_low(table_pointer_low), .table_pointer_high(table_pointer_high),
    .current_page(current_page), .prog_rd_data(prog_rd_data), .busy(busy), .skip_next(skip_next),
    .work_register(work_register), .signed_range_flag(signed_range_flag),
    .result_null_flag(result_null_flag), .half_byte_borrow_flag(half_byte_borrow_flag),
    .borrow_inverse_flag(borrow_inverse_flag), .table_high_latch(table_high_latch),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .prog_rd_en(prog_rd_en), .prog_rd_addr(prog_rd_addr)
  );

  always #50 core_clk = ~core_clk;

  // ********************************************
  // Reporting
  // ********************************************
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check_val(input logic [23:0] got, input logic [23:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Cycle budget well above the whole sequence
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end

  // ********************************************
  // Drivers
  // ********************************************
  // Entered just after an edge; returns just after the accepting edge
  // Valid stays high so back-to-back calls never lower and raise it in one step
  task automatic issue(input csx_pkg::csx_op_e op, input logic [7:0] addr, input logic [7:0] imm,
                       input logic [7:0] mem, input logic [2:0] bsel);
    instr_valid = 1'b1;
    instr_op    = op;
    instr_addr  = addr;
    instr_imm   = imm;
    instr_bit   = bsel;
    mem_rd_data = mem;
    @(posedge core_clk);
    #10;
  endtask

  // Nonzero copy never skips, so it serves as a work register load
  task automatic load(input logic [7:0] v);
    issue(csx_pkg::CSX_OP_COPY_SKIP, 8'h00, 8'h00, v, 3'h0);
    check_val(work_register, v, "load");
  endtask

  // ********************************************
  // Scenarios
  // ********************************************
  task automatic sub_case(input logic [7:0] w, input logic [7:0] i, input logic [7:0] r, input logic [3:0] f);
    load(w);
    issue(csx_pkg::CSX_OP_SUB_IMM, 8'h00, i, 8'h00, 3'h0);
    check_val(work_register, r, "sub result");
    check_val(flags, f, "sub flags");
  endtask

  task automatic t_xor;
    issue(csx_pkg::CSX_OP_XOR_IMM, 8'h00, 8'h5a, 8'h00, 3'h0);
    check_val({work_register, 4'h0, flags}, 16'h5a03, "xor imm");
    issue(csx_pkg::CSX_OP_XOR_WORK, 8'h12, 8'h00, 8'h5a, 3'h0);
    check_val({work_register, 4'h0, flags}, 16'h0007, "xor work");
    check_bit(mem_wr_en, 1'b0, "xor work write");
    issue(csx_pkg::CSX_OP_XOR_MEM, 8'h34, 8'h00, 8'hff, 3'h0);
    check_val({mem_wr_en, mem_wr_addr, mem_wr_data}, {1'b1, 8'h34, 8'hff}, "xor mem write");
    check_val({work_register, 4'h0, flags}, 16'h0003, "xor mem state");
  endtask

  task automatic t_swap;
    load(8'h11);
    issue(csx_pkg::CSX_OP_SWAP_MEM, 8'h40, 8'h00, 8'h3c, 3'h0);
    check_val({mem_wr_en, mem_wr_addr, mem_wr_data}, {1'b1, 8'h40, 8'hc3}, "swap mem write");
    check_val({work_register, 4'h0, flags}, 16'h1103, "swap mem state");
    issue(csx_pkg::CSX_OP_SWAP_WORK, 8'h41, 8'h00, 8'h96, 3'h0);
    check_val({work_register, 4'h0, flags}, 16'h6903, "swap work");
    check_bit(mem_wr_en, 1'b0, "swap work write");
  endtask

  // Follower is an XOR into memory; it must vanish when skipped
  task automatic skip_case(input csx_pkg::csx_op_e op, input logic [7:0] mem, input logic [2:0] bsel,
                           input logic sk, input logic [7:0] w);
    issue(op, 8'h20, 8'h00, mem, bsel);
    check_bit(skip_next, sk, "skip pulse");
    check_bit(busy, sk, "dummy cycle busy");
    check_val({work_register, 4'h0, flags}, {w, 8'h03}, "skip state");
    if (sk) begin
      instr_valid = 1'b0;
      @(posedge core_clk);
      #10;
      check_val({busy, skip_next}, 2'b00, "after dummy");
    end
    issue(csx_pkg::CSX_OP_XOR_MEM, 8'h21, 8'h00, 8'h0f, 3'h0);
    check_bit(mem_wr_en, !sk, "follower write");
    if (!sk) begin
      check_val(mem_wr_data, w ^ 8'h0f, "follower data");
    end
    check_val(work_register, w, "follower work");
  endtask

  task automatic t_skip;
    load(8'h21);
    skip_case(csx_pkg::CSX_OP_SKIP_BYTE, 8'h00, 3'h0, 1'b1, 8'h21);
    skip_case(csx_pkg::CSX_OP_SKIP_BYTE, 8'h01, 3'h0, 1'b0, 8'h21);
    skip_case(csx_pkg::CSX_OP_COPY_SKIP, 8'h00, 3'h0, 1'b1, 8'h00);
    skip_case(csx_pkg::CSX_OP_COPY_SKIP, 8'h80, 3'h0, 1'b0, 8'h80);
    skip_case(csx_pkg::CSX_OP_SKIP_BIT, 8'hf7, 3'h3, 1'b1, 8'h80);
    skip_case(csx_pkg::CSX_OP_SKIP_BIT, 8'h08, 3'h3, 1'b0, 8'h80);
    skip_case(csx_pkg::CSX_OP_SKIP_BIT, 8'h7f, 3'h7, 1'b1, 8'h80);
    skip_case(csx_pkg::CSX_OP_SKIP_BIT, 8'h01, 3'h0, 1'b0, 8'h80);
  endtask

  task automatic tab_case(input csx_pkg::csx_op_e op, input logic [2:0] page, input logic [15:0] word);
    issue(op, 8'h55, 8'h00, 8'h00, 3'h0);
    instr_valid = 1'b0;
    check_val({prog_rd_en, busy, prog_rd_addr}, {2'b11, page, 8'hc3}, "table fetch");
    @(posedge core_clk);
    #10;
    prog_rd_data = word;
    check_val({prog_rd_en, busy}, 2'b01, "table wait");
    @(posedge core_clk);
    #10;
    prog_rd_data = ~word;
    check_val({mem_wr_en, mem_wr_addr, mem_wr_data}, {1'b1, 8'h55, word[7:0]}, "table low byte");
    check_val({table_high_latch, work_register}, {word[15:8], 8'h80}, "table high byte");
    check_val({busy, flags}, 5'b00011, "table end state");
  endtask

  task automatic t_table;
    tab_case(csx_pkg::CSX_OP_TAB_FIXED, 3'h2, 16'ha55a);
    tab_case(csx_pkg::CSX_OP_TAB_CURRENT, 3'h5, 16'h3cc3);
    tab_case(csx_pkg::CSX_OP_TAB_LAST, `CSX_LAST_PAGE, 16'h0ff0);
  endtask

  // ********************************************
  // Main sequence
  // ********************************************
  initial begin
    core_clk           = 1'b0;
    rst_n              = 1'b0;
    instr_valid        = 1'b0;
    instr_op           = csx_pkg::CSX_OP_SUB_IMM;
    instr_addr         = 8'h00;
    instr_imm          = 8'h00;
    instr_bit          = 3'h0;
    mem_rd_data        = 8'h00;
    table_pointer_low  = 8'hc3;
    table_pointer_high = 3'h2;
    current_page       = 3'h5;
    prog_rd_data       = 16'h0000;
    fail_count         = 0;
    cmp_count          = 0;
    cycles             = 0;
    repeat (12) @(posedge core_clk);
    #10;
    rst_n = 1'b1;
    check_val({busy, skip_next, work_register, flags}, 14'h0000, "reset state");
    sub_case(8'h10, 8'h20, 8'hf0, 4'b0010);
    sub_case(8'h80, 8'h01, 8'h7f, 4'b1001);
    sub_case(8'h7f, 8'hff, 8'h80, 4'b1010);
    sub_case(8'h05, 8'h05, 8'h00, 4'b0111);
    t_xor();
    t_swap();
    t_skip();
    t_table();
    conclude();
  end
endmodule

//--- verilog/csx_alu.sv
// Combinational result, flag and skip condition for one instruction.
// Assumes operands stay steady for the cycle in which the core samples them.
`timescale 1ns/1ns
`include "csx_regs.svh"

module csx_alu (
  csx_alu_if.alu alu_io
);

  logic [`CSX_BYTE_W:0] diff;
  logic [`CSX_NIB_W:0]  nib_diff;
  logic [`CSX_BYTE_W-1:0] swapped;

  assign swapped = {alu_io.mem[`CSX_NIB_W-1:0], alu_io.mem[`CSX_BYTE_W-1:`CSX_NIB_W]};

  always_comb begin
    diff     = {1'b0, alu_io.work} - {1'b0, alu_io.imm};
    nib_diff = {1'b0, alu_io.work[`CSX_NIB_W-1:0]} - {1'b0, alu_io.imm[`CSX_NIB_W-1:0]};
    // Overflow when operand signs differ and the result sign leaves the minuend
    alu_io.range_flag = (alu_io.work[`CSX_BYTE_W-1] ^ alu_io.imm[`CSX_BYTE_W-1]) &
                        (diff[`CSX_BYTE_W-1] ^ alu_io.work[`CSX_BYTE_W-1]);
    alu_io.half_flag  = ~nib_diff[`CSX_NIB_W];
    alu_io.borrow_inv = ~diff[`CSX_BYTE_W];
    alu_io.skip_cond  = 1'b0;
    alu_io.result     = alu_io.work;
    unique case (alu_io.op)
      csx_pkg::CSX_OP_SUB_IMM: begin
        alu_io.result = diff[`CSX_BYTE_W-1:0];
      end
      csx_pkg::CSX_OP_SWAP_MEM,
      csx_pkg::CSX_OP_SWAP_WORK: begin
        alu_io.result = swapped;
      end
      csx_pkg::CSX_OP_SKIP_BYTE: begin
        alu_io.skip_cond = (alu_io.mem == `CSX_BYTE_ZERO);
      end
      csx_pkg::CSX_OP_COPY_SKIP: begin
        alu_io.result    = alu_io.mem;
        alu_io.skip_cond = (alu_io.mem == `CSX_BYTE_ZERO);
      end
      csx_pkg::CSX_OP_SKIP_BIT: begin
        alu_io.skip_cond = ~alu_io.mem[alu_io.bit_sel];
      end
      csx_pkg::CSX_OP_XOR_WORK,
      csx_pkg::CSX_OP_XOR_MEM: begin
        alu_io.result = alu_io.work ^ alu_io.mem;
      end
      csx_pkg::CSX_OP_XOR_IMM: begin
        alu_io.result = alu_io.work ^ alu_io.imm;
      end
      default: begin
        alu_io.result = alu_io.work;
      end
    endcase
  end

endmodule

//--- verilog/csx_alu_if.sv
// Operand and result bundle between the execution core and its ALU.
// Assumes csx_pkg is compiled first.
`timescale 1ns/1ns
`include "csx_regs.svh"

interface csx_alu_if;
  csx_pkg::csx_op_e           op;
  logic [`CSX_BYTE_W-1:0]     work;
  logic [`CSX_BYTE_W-1:0]     mem;
  logic [`CSX_BYTE_W-1:0]     imm;
  logic [`CSX_BIT_W-1:0]      bit_sel;
  logic [`CSX_BYTE_W-1:0]     result;
  logic                       range_flag;
  logic                       half_flag;
  logic                       borrow_inv;
  logic                       skip_cond;

  modport alu  (input op, work, mem, imm, bit_sel,
                output result, range_flag, half_flag, borrow_inv, skip_cond);
  modport core (output op, work, mem, imm, bit_sel,
                input result, range_flag, half_flag, borrow_inv, skip_cond);
endinterface

//--- verilog/csx_exec.sv
// Execution unit for subtract-immediate, nibble swap, zero skips, table reads and XOR.
// Assumes the sequencer presents one instruction per instr_valid pulse with its memory
// operand already on mem_rd_data, and that program memory answers one cycle after a read.
`timescale 1ns/1ns
`include "csx_regs.svh"

module csx_exec (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      instr_valid,
  input  wire csx_pkg::csx_op_e          instr_op,
  input  wire logic [`CSX_MEM_AW-1:0]    instr_addr,
  input  wire logic [`CSX_BYTE_W-1:0]    instr_imm,
  input  wire logic [`CSX_BIT_W-1:0]     instr_bit,
  input  wire logic [`CSX_BYTE_W-1:0]    mem_rd_data,
  input  wire logic [`CSX_BYTE_W-1:0]    table_pointer_low,
  input  wire logic [`CSX_PAGE_W-1:0]    table_pointer_high,
  input  wire logic [`CSX_PAGE_W-1:0]    current_page,
  input  wire logic [`CSX_WORD_W-1:0]    prog_rd_data,
  output logic                           busy,
  output logic                           skip_next,
  output logic [`CSX_BYTE_W-1:0]         work_register,
  output logic                           signed_range_flag,
  output logic                           result_null_flag,
  output logic                           half_byte_borrow_flag,
  output logic                           borrow_inverse_flag,
  output logic [`CSX_BYTE_W-1:0]         table_high_latch,
  output logic                           mem_wr_en,
  output logic [`CSX_MEM_AW-1:0]         mem_wr_addr,
  output logic [`CSX_BYTE_W-1:0]         mem_wr_data,
  output logic                           prog_rd_en,
  output logic [`CSX_PROG_AW-1:0]        prog_rd_addr
);

  csx_pkg::csx_state_s state_reg;
  csx_pkg::csx_state_s state_next;
  logic                accept;
  logic                drop;

  csx_alu_if alu_bus ();

  csx_alu u_alu (
    .alu_io (alu_bus)
  );

  // ********************************************
  // ALU operands
  // ********************************************
  assign alu_bus.op      = instr_op;
  assign alu_bus.work    = state_reg.work;
  assign alu_bus.mem     = mem_rd_data;
  assign alu_bus.imm     = instr_imm;
  assign alu_bus.bit_sel = instr_bit;

  assign busy   = (state_reg.fsm != csx_pkg::CSX_IDLE);
  assign accept = instr_valid && !busy && !state_reg.discard;
  assign drop   = instr_valid && !busy && state_reg.discard;

  // ********************************************
  // Next state
  // ********************************************
  always_comb begin
    state_next            = state_reg;
    state_next.mem_wr_en  = 1'b0;
    state_next.skip_next  = 1'b0;
    state_next.prog_rd_en = 1'b0;
    unique case (state_reg.fsm)
      csx_pkg::CSX_IDLE: begin
        if (drop) begin
          state_next.discard = 1'b0;
        end else if (accept) begin
          unique case (instr_op)
            csx_pkg::CSX_OP_SUB_IMM: begin
              state_next.work                  = alu_bus.result;
              state_next.signed_range_flag     = alu_bus.range_flag;
              state_next.result_null_flag      = (alu_bus.result == `CSX_BYTE_ZERO);
              state_next.half_byte_borrow_flag = alu_bus.half_flag;
              state_next.borrow_inverse_flag   = alu_bus.borrow_inv;
            end
            csx_pkg::CSX_OP_SWAP_MEM,
            csx_pkg::CSX_OP_XOR_MEM: begin
              state_next.mem_wr_en   = 1'b1;
              state_next.mem_wr_addr = instr_addr;
              state_next.mem_wr_data = alu_bus.result;
              if (instr_op == csx_pkg::CSX_OP_XOR_MEM) begin
                state_next.result_null_flag = (alu_bus.result == `CSX_BYTE_ZERO);
              end
            end
            csx_pkg::CSX_OP_SWAP_WORK,
            csx_pkg::CSX_OP_COPY_SKIP: begin
              state_next.work = alu_bus.result;
            end
            csx_pkg::CSX_OP_XOR_WORK,
            csx_pkg::CSX_OP_XOR_IMM: begin
              state_next.work             = alu_bus.result;
              state_next.result_null_flag = (alu_bus.result == `CSX_BYTE_ZERO);
            end
            csx_pkg::CSX_OP_TAB_FIXED: begin
              state_next.prog_rd_addr = {table_pointer_high, table_pointer_low};
            end
            csx_pkg::CSX_OP_TAB_CURRENT: begin
              state_next.prog_rd_addr = {current_page, table_pointer_low};
            end
            csx_pkg::CSX_OP_TAB_LAST: begin
              state_next.prog_rd_addr = {`CSX_LAST_PAGE, table_pointer_low};
            end
            default: begin
              state_next.work = state_reg.work;
            end
          endcase
          if (instr_op == csx_pkg::CSX_OP_TAB_FIXED || instr_op == csx_pkg::CSX_OP_TAB_CURRENT ||
              instr_op == csx_pkg::CSX_OP_TAB_LAST) begin
            state_next.prog_rd_en = 1'b1;
            state_next.tab_dest   = instr_addr;
            state_next.fsm        = csx_pkg::CSX_TAB_WAIT;
          end
          // Skip: hold one dummy cycle, then swallow the fetched instruction
          if (alu_bus.skip_cond) begin
            state_next.skip_next = 1'b1;
            state_next.discard   = 1'b1;
            state_next.fsm       = csx_pkg::CSX_DUMMY;
          end
        end
      end
      csx_pkg::CSX_DUMMY: begin
        state_next.fsm = csx_pkg::CSX_IDLE;
      end
      csx_pkg::CSX_TAB_WAIT: begin
        state_next.fsm = csx_pkg::CSX_TAB_DATA;
      end
      csx_pkg::CSX_TAB_DATA: begin
        state_next.mem_wr_en   = 1'b1;
        state_next.mem_wr_addr = state_reg.tab_dest;
        state_next.mem_wr_data = prog_rd_data[`CSX_BYTE_W-1:0];
        state_next.tbl_high    = prog_rd_data[`CSX_WORD_W-1:`CSX_BYTE_W];
        state_next.fsm         = csx_pkg::CSX_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= csx_pkg::CSX_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ********************************************
  // Outputs
  // ********************************************
  assign skip_next             = state_reg.skip_next;
  assign work_register         = state_reg.work;
  assign signed_range_flag     = state_reg.signed_range_flag;
  assign result_null_flag      = state_reg.result_null_flag;
  assign half_byte_borrow_flag = state_reg.half_byte_borrow_flag;
  assign borrow_inverse_flag   = state_reg.borrow_inverse_flag;
  assign table_high_latch      = state_reg.tbl_high;
  assign mem_wr_en             = state_reg.mem_wr_en;
  assign mem_wr_addr           = state_reg.mem_wr_addr;
  assign mem_wr_data           = state_reg.mem_wr_data;
  assign prog_rd_en            = state_reg.prog_rd_en;
  assign prog_rd_addr          = state_reg.prog_rd_addr;

  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_sub_result;
    accept && instr_op == csx_pkg::CSX_OP_SUB_IMM |=>
      work_register == $past(work_register) - $past(instr_imm) &&
      result_null_flag == (work_register == `CSX_BYTE_ZERO);
  endproperty
  a_sub_result: assert property (p_sub_result) else $error("subtract result wrong");

  property p_sub_borrow;
    accept && instr_op == csx_pkg::CSX_OP_SUB_IMM |=>
      borrow_inverse_flag == ($past(work_register) >= $past(instr_imm));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow) else $error("borrow flag wrong");

  property p_swap_mem;
    accept && instr_op == csx_pkg::CSX_OP_SWAP_MEM |=>
      mem_wr_en && mem_wr_addr == $past(instr_addr) &&
      mem_wr_data == {$past(mem_rd_data[`CSX_NIB_W-1:0]), $past(mem_rd_data[`CSX_BYTE_W-1:`CSX_NIB_W])} &&
      $stable(result_null_flag) && $stable(borrow_inverse_flag);
  endproperty
  a_swap_mem: assert property (p_swap_mem) else $error("memory swap wrong");

  property p_swap_work;
    accept && instr_op == csx_pkg::CSX_OP_SWAP_WORK |=>
      !mem_wr_en && $stable(result_null_flag) &&
      work_register == {$past(mem_rd_data[`CSX_NIB_W-1:0]), $past(mem_rd_data[`CSX_BYTE_W-1:`CSX_NIB_W])};
  endproperty
  a_swap_work: assert property (p_swap_work) else $error("work swap wrong");

  property p_skip_byte;
    accept && instr_op == csx_pkg::CSX_OP_SKIP_BYTE |=>
      skip_next == ($past(mem_rd_data) == `CSX_BYTE_ZERO) && $stable(result_null_flag);
  endproperty
  a_skip_byte: assert property (p_skip_byte) else $error("byte skip wrong");

  property p_dummy;
    skip_next |-> busy ##1 (!busy && !skip_next);
  endproperty
  a_dummy: assert property (p_dummy) else $error("skip dummy cycle wrong");

  property p_copy_skip;
    accept && instr_op == csx_pkg::CSX_OP_COPY_SKIP |=>
      work_register == $past(mem_rd_data) && skip_next == (work_register == `CSX_BYTE_ZERO);
  endproperty
  a_copy_skip: assert property (p_copy_skip) else $error("copy skip wrong");

  property p_skip_bit;
    accept && instr_op == csx_pkg::CSX_OP_SKIP_BIT |=>
      skip_next == ((($past(mem_rd_data) >> $past(instr_bit)) & `CSX_BIT_ONE) == `CSX_BYTE_ZERO);
  endproperty
  a_skip_bit: assert property (p_skip_bit) else $error("bit skip wrong");

  property p_tab_fixed;
    accept && instr_op == csx_pkg::CSX_OP_TAB_FIXED |=>
      prog_rd_en && prog_rd_addr == {$past(table_pointer_high), $past(table_pointer_low)} ##2
      mem_wr_en && mem_wr_data == $past(prog_rd_data[`CSX_BYTE_W-1:0]) &&
      table_high_latch == $past(prog_rd_data[`CSX_WORD_W-1:`CSX_BYTE_W]);
  endproperty
  a_tab_fixed: assert property (p_tab_fixed) else $error("fixed page read wrong");

  property p_tab_current;
    accept && instr_op == csx_pkg::CSX_OP_TAB_CURRENT |=>
      prog_rd_en && prog_rd_addr == {$past(current_page), $past(table_pointer_low)};
  endproperty
  a_tab_current: assert property (p_tab_current) else $error("current page read wrong");

  property p_tab_last;
    accept && instr_op == csx_pkg::CSX_OP_TAB_LAST |=>
      prog_rd_en && prog_rd_addr == {`CSX_LAST_PAGE, $past(table_pointer_low)} ##2
      mem_wr_en && $stable(result_null_flag);
  endproperty
  a_tab_last: assert property (p_tab_last) else $error("last page read wrong");

  property p_xor_work;
    accept && instr_op == csx_pkg::CSX_OP_XOR_WORK |=>
      work_register == ($past(work_register) ^ $past(mem_rd_data)) &&
      result_null_flag == (work_register == `CSX_BYTE_ZERO) && $stable(borrow_inverse_flag);
  endproperty
  a_xor_work: assert property (p_xor_work) else $error("xor to work wrong");

  property p_xor_mem;
    accept && instr_op == csx_pkg::CSX_OP_XOR_MEM |=>
      mem_wr_en && mem_wr_data == ($past(work_register) ^ $past(mem_rd_data)) &&
      $stable(work_register) && result_null_flag == (mem_wr_data == `CSX_BYTE_ZERO);
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");

  property p_xor_imm;
    accept && instr_op == csx_pkg::CSX_OP_XOR_IMM |=>
      work_register == ($past(work_register) ^ $past(instr_imm)) && $stable(signed_range_flag);
  endproperty
  a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong");

  property p_discard;
    drop |=> $stable(work_register) && $stable(result_null_flag) && !mem_wr_en && !prog_rd_en && !skip_next;
  endproperty
  a_discard: assert property (p_discard) else $error("skipped instruction had effect");

endmodule

//--- verilog/csx_pkg.sv
// Types of the instruction execution block: opcodes, states and state record.
// Assumes csx_regs.svh is on the include path.
`include "csx_regs.svh"

package csx_pkg;

  // ********************************************
  // Operations handled here
  // ********************************************
  typedef enum logic [3:0] {
    CSX_OP_SUB_IMM,
    CSX_OP_SWAP_MEM,
    CSX_OP_SWAP_WORK,
    CSX_OP_SKIP_BYTE,
    CSX_OP_COPY_SKIP,
    CSX_OP_SKIP_BIT,
    CSX_OP_TAB_FIXED,
    CSX_OP_TAB_CURRENT,
    CSX_OP_TAB_LAST,
    CSX_OP_XOR_WORK,
    CSX_OP_XOR_MEM,
    CSX_OP_XOR_IMM
  } csx_op_e;

  typedef enum logic [1:0] {
    CSX_IDLE,
    CSX_DUMMY,
    CSX_TAB_WAIT,
    CSX_TAB_DATA
  } csx_fsm_e;

  // ********************************************
  // Whole state of the execution block
  // ********************************************
  typedef struct packed {
    csx_fsm_e                   fsm;
    logic [`CSX_BYTE_W-1:0]     work;
    logic                       signed_range_flag;
    logic                       result_null_flag;
    logic                       half_byte_borrow_flag;
    logic                       borrow_inverse_flag;
    logic [`CSX_BYTE_W-1:0]     tbl_high;
    logic                       mem_wr_en;
    logic [`CSX_MEM_AW-1:0]     mem_wr_addr;
    logic [`CSX_BYTE_W-1:0]     mem_wr_data;
    logic                       skip_next;
    logic                       discard;
    logic                       prog_rd_en;
    logic [`CSX_PROG_AW-1:0]    prog_rd_addr;
    logic [`CSX_MEM_AW-1:0]     tab_dest;
  } csx_state_s;

  localparam csx_state_s CSX_STATE_RST = '{fsm: CSX_IDLE, default: '0};

endpackage

//--- verilog/csx_regs.svh
// Widths, pages and constant values of the instruction execution block.
// Assumes nothing; definitions only.
`ifndef CSX_REGS_SVH
`define CSX_REGS_SVH

// ********************************************
// Data path sizes
// ********************************************
`define CSX_BYTE_W    8
`define CSX_NIB_W     4
`define CSX_BIT_W     3
`define CSX_MEM_AW    8
`define CSX_WORD_W    16
`define CSX_PAGE_W    3
`define CSX_PROG_AW   (`CSX_PAGE_W + `CSX_BYTE_W)

// ********************************************
// Fixed values
// ********************************************
`define CSX_LAST_PAGE 3'h7
`define CSX_BYTE_ZERO 8'h00
`define CSX_BIT_ONE   8'h01

`endif
